/* File: hw/utx_fifo.sv */
/*
  Flip-flop FIFO with valid and ready on both sides and a fill level.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module utx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 212,
  parameter int LW    = $clog2(DEPTH + 1),
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data,
  output logic      [LW-1:0]    level
);

  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic             do_wr;
  logic             do_rd;

  assign wr_ready = (level != LVL_FULL);
  assign rd_valid = (level != '0);
  assign rd_data  = mem[rd_ptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  always_ff @(posedge clock)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        level <= level + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        level <= level - 1'b1;
      end
    end
  end

endmodule : utx_fifo

/* File: hw/utx_pkg.sv */
/*
  Types shared by the transmit cell port.
  Assumes utx_regs.svh carries the numeric constants.
*/
package utx_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       soc;
  } utx_wr_s;

  typedef enum logic [0:0] {
    UTX_SRC_IDLE = 1'b0,
    UTX_SRC_FIFO = 1'b1
  } utx_src_e;

endpackage : utx_pkg

/* File: hw/utx_regs.svh */
/*
  Register offsets, field positions, reset values and timing counts of the transmit cell port.
  Assumes a 32-bit APB register bus with byte addresses and one aligned word per register.
*/
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH

`define UTX_ADDR_CTRL        12'h000
`define UTX_ADDR_STATUS      12'h004
`define UTX_ADDR_MASK        12'h008
`define UTX_ADDR_LEVEL       12'h00c

`define UTX_CTRL_PAR_EVEN    0
`define UTX_CTRL_LVL_ZERO    1
`define UTX_CTRL_THR_LO      2
`define UTX_CTRL_THR_HI      3
`define UTX_CTRL_POL         4
`define UTX_CTRL_GFC_EN      5
`define UTX_CTRL_RESET       6'h00

`define UTX_ST_PARITY        0
`define UTX_ST_SOC           1
`define UTX_ST_OVERFLOW      2
`define UTX_ST_RESET         3'h0
`define UTX_MASK_RESET       3'h0
`define UTX_LEVEL_IDLE_BIT   16

`define UTX_CELL_BYTES       53
`define UTX_CELL_LAST        6'h34
`define UTX_GFC_MARK_IDX     6'h30
`define UTX_GFC_FIRST_IDX    6'h31
`define UTX_FIFO_CELLS       4
`define UTX_BYTE_DIV         8

`define UTX_IDLE_HDR3        8'h01
`define UTX_IDLE_HEC         8'h52
`define UTX_IDLE_FILL        8'h6a

`endif

/* File: hw/utx_sync.sv */
/*
  Two-flip-flop synchroniser for one level.
  Assumes the input may change at any time relative to clock.
*/
`timescale 1ns/1ps
module utx_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  // Only the second stage reads the first, so a metastable value never fans out.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : utx_sync

/* File: hw/utx_tx_cell_port.sv */
/*
  Transmit cell entry port: byte writes with parity and start of cell into a cell FIFO, cell-available status,
  forced idle cells, serial flow-control overwrite, byte clock divider and an APB register slave with interrupt.
  Assumes all writer inputs are synchronous to clock and force_idle_cells is fully asynchronous.
*/
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "utx_regs.svh"

module utx_tx_cell_port
  import utx_pkg::*;
#(
  parameter int FIFO_CELLS = `UTX_FIFO_CELLS,
  parameter int BYTE_DIV   = `UTX_BYTE_DIV
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  tx_cell_data,
  input  wire logic        tx_cell_parity,
  input  wire logic        tx_start_of_cell,
  input  wire logic        tx_write_enable_n,
  output logic             tx_cell_avail,
  input  wire logic        force_idle_cells,
  input  wire logic        serial_flow_ctrl_in,
  output logic             flow_ctrl_marker,
  output logic             tx_byte_clock,
  output logic      [7:0]  tx_line_data,
  output logic             tx_line_idle
);

  localparam int DEPTH = FIFO_CELLS * `UTX_CELL_BYTES;
  localparam int LW    = $clog2(DEPTH + 1);
  localparam int DW    = $clog2(BYTE_DIV);
  localparam logic [LW-1:0] DEPTH_L  = LW'(DEPTH);
  localparam logic [LW-1:0] CELL_L   = LW'(`UTX_CELL_BYTES);
  localparam logic [DW-1:0] DIV_LAST = DW'(BYTE_DIV - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(BYTE_DIV / 2);

  function automatic logic parity_bad(input logic [7:0] d, input logic p, input logic even);
    parity_bad = ((^{d, p}) == even);
  endfunction : parity_bad

  function automatic logic [5:0] cell_step(input logic [5:0] idx);
    cell_step = (idx == `UTX_CELL_LAST) ? 6'h00 : idx + 6'h01;
  endfunction : cell_step

  utx_wr_s         wr;
  logic [5:0]      ctrl;
  logic [2:0]      status;
  logic [2:0]      mask;
  logic            started;
  logic [5:0]      wr_idx;
  logic            accept;
  logic            take;
  logic            fifo_wr_ready;
  logic            fifo_rd_valid;
  logic            fifo_rd_ready;
  logic [7:0]      fifo_rd_data;
  logic [LW-1:0]   level;
  logic [LW-1:0]   free_cells;
  logic            avail_raw;
  logic            idle_sync;
  logic [DW-1:0]   div_cnt;
  logic [DW-1:0]   next_div;
  logic            tick;
  utx_src_e        rd_src;
  logic [5:0]      rd_idx;
  logic [3:0]      gfc_bits;
  logic [7:0]      next_line;
  logic [2:0]      evt;
  logic            apb_acc;
  logic            apb_wr;
  logic [31:0]     rd_mux;
  logic            addr_ok;

  assign wr = '{data: tx_cell_data, parity: tx_cell_parity, soc: tx_start_of_cell};

  // Writes before the first start of cell are dropped so the FIFO starts cell-aligned.
  assign accept = !tx_write_enable_n;
  assign take   = accept && (started || wr.soc);

  assign evt[`UTX_ST_PARITY]   = accept && parity_bad(wr.data, wr.parity, ctrl[`UTX_CTRL_PAR_EVEN]);
  assign evt[`UTX_ST_SOC]      = accept && wr.soc && started && (wr_idx != 6'h00);
  assign evt[`UTX_ST_OVERFLOW] = take && !fifo_wr_ready;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      started <= 1'b0;
      wr_idx  <= 6'h00;
    end
    else if (take)
    begin
      started <= 1'b1;
      // A start of cell realigns the count; otherwise every 53 taken bytes close a cell.
      wr_idx  <= wr.soc ? 6'h01 : cell_step(wr_idx);
    end
  end

  utx_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .LW    (LW)
  ) u_fifo (
    .clock    (clock),
    .rst      (rst),
    .wr_valid (take),
    .wr_ready (fifo_wr_ready),
    .wr_data  (wr.data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .level    (level)
  );

  assign free_cells = (DEPTH_L - level) / CELL_L;
  assign avail_raw  = (ctrl[`UTX_CTRL_THR_HI:`UTX_CTRL_THR_LO] == 2'b00 && !ctrl[`UTX_CTRL_LVL_ZERO])
                    ? !fifo_wr_ready
                    : (free_cells >= LW'(ctrl[`UTX_CTRL_THR_HI:`UTX_CTRL_THR_LO]));

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tx_cell_avail <= 1'b0;
    end
    else
    begin
      tx_cell_avail <= avail_raw ^ ctrl[`UTX_CTRL_POL];
    end
  end

  // The reset value of the synchroniser stands in for the pull-down of an undriven pin.
  utx_sync u_idle_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (force_idle_cells),
    .sync_out (idle_sync)
  );

  assign next_div = (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
  assign tick     = (div_cnt == DIV_LAST);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      div_cnt       <= '0;
      tx_byte_clock <= 1'b0;
    end
    else
    begin
      div_cnt       <= next_div;
      tx_byte_clock <= (next_div < DIV_HALF);
    end
  end

  assign fifo_rd_ready = tick && (rd_src == UTX_SRC_FIFO);

  always_comb
  begin
    next_line = `UTX_IDLE_FILL;
    if (rd_src == UTX_SRC_FIFO)
    begin
      next_line = fifo_rd_data;
      if (rd_idx == 6'h00 && ctrl[`UTX_CTRL_GFC_EN])
      begin
        next_line = {gfc_bits, fifo_rd_data[3:0]};
      end
    end
    else if (rd_idx == 6'h03)
    begin
      next_line = `UTX_IDLE_HDR3;
    end
    else if (rd_idx == 6'h04)
    begin
      next_line = `UTX_IDLE_HEC;
    end
    else if (rd_idx < 6'h03)
    begin
      next_line = 8'h00;
    end
  end

  // The next cell source is chosen only at a cell boundary, so a cell already started is never cut short.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_src       <= UTX_SRC_IDLE;
      rd_idx       <= 6'h00;
      tx_line_data <= 8'h00;
      tx_line_idle <= 1'b1;
    end
    else if (tick)
    begin
      tx_line_data <= next_line;
      tx_line_idle <= (rd_src == UTX_SRC_IDLE);
      rd_idx       <= cell_step(rd_idx);
      if (rd_idx == `UTX_CELL_LAST)
      begin
        case (rd_src)
          UTX_SRC_IDLE,
          UTX_SRC_FIFO:
          begin
            rd_src <= (!idle_sync && level >= CELL_L + LW'(rd_src == UTX_SRC_FIFO))
                    ? UTX_SRC_FIFO : UTX_SRC_IDLE;
          end
          default:
          begin
            rd_src <= UTX_SRC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flow_ctrl_marker <= 1'b0;
      gfc_bits         <= 4'h0;
    end
    else if (tick)
    begin
      // The marker spans the byte period before the first bit, which is taken at the next byte clock rise.
      flow_ctrl_marker <= (rd_idx == `UTX_GFC_MARK_IDX);
      if (rd_idx >= `UTX_GFC_FIRST_IDX)
      begin
        gfc_bits <= {gfc_bits[2:0], serial_flow_ctrl_in};
      end
    end
  end

  assign apb_acc = psel && penable && pready;
  assign apb_wr  = apb_acc && pwrite;
  assign addr_ok = (paddr == `UTX_ADDR_CTRL) || (paddr == `UTX_ADDR_STATUS) ||
                   (paddr == `UTX_ADDR_MASK) || (paddr == `UTX_ADDR_LEVEL);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `UTX_ADDR_CTRL:   rd_mux = {26'h000_0000, ctrl};
      `UTX_ADDR_STATUS: rd_mux = {29'h000_0000, status};
      `UTX_ADDR_MASK:   rd_mux = {29'h000_0000, mask};
      `UTX_ADDR_LEVEL:  rd_mux = {15'h0000, idle_sync, 16'(level)};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl <= `UTX_CTRL_RESET;
      mask <= `UTX_MASK_RESET;
    end
    else if (apb_wr)
    begin
      if (paddr == `UTX_ADDR_CTRL)
      begin
        ctrl <= pwdata[5:0];
      end
      if (paddr == `UTX_ADDR_MASK)
      begin
        mask <= pwdata[2:0];
      end
    end
  end

  // A new event in the clearing cycle survives, since the set term is applied after the clear.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      status <= `UTX_ST_RESET;
      irq    <= 1'b0;
    end
    else
    begin
      status <= (status & ~((apb_wr && paddr == `UTX_ADDR_STATUS) ? pwdata[2:0] : 3'h0)) | evt;
      irq    <= |(status & mask);
    end
  end

  a_write_enable: assert property (@(posedge clock) disable iff (rst)
    tx_write_enable_n |=> level <= $past(level)) else $error("byte taken with write enable high");
  a_first_soc: assert property (@(posedge clock) disable iff (rst)
    (!started && !tx_start_of_cell) |=> level <= $past(level)) else $error("byte taken before first start of cell");
  a_soc_error: assert property (@(posedge clock) disable iff (rst)
    (accept && tx_start_of_cell && started && wr_idx != 6'h00) |=> status[`UTX_ST_SOC])
    else $error("early start of cell not flagged");
  a_parity_flag: assert property (@(posedge clock) disable iff (rst)
    (accept && ((^{tx_cell_data, tx_cell_parity}) == ctrl[`UTX_CTRL_PAR_EVEN])) |=> status[`UTX_ST_PARITY])
    else $error("parity error not flagged");
  a_cell_count: assert property (@(posedge clock) disable iff (rst)
    (take && !tx_start_of_cell && wr_idx == `UTX_CELL_LAST) |=> wr_idx == 6'h00)
    else $error("cell count did not wrap after 53 bytes");
  a_full_mode: assert property (@(posedge clock) disable iff (rst)
    (ctrl == 6'h00 && $stable(ctrl)) |=> tx_cell_avail == !$past(fifo_wr_ready))
    else $error("cell available is not the full flag");
  a_idle_force: assert property (@(posedge clock) disable iff (rst)
    (tick && idle_sync && rd_idx == `UTX_CELL_LAST) |=> rd_src == UTX_SRC_IDLE)
    else $error("cell taken from FIFO while idle forced");
  a_marker_place: assert property (@(posedge clock) disable iff (rst)
    $rose(flow_ctrl_marker) |-> rd_idx == `UTX_GFC_FIRST_IDX && $past(tick))
    else $error("flow-control marker out of place");
  a_gfc_replace: assert property (@(posedge clock) disable iff (rst)
    (tick && rd_src == UTX_SRC_FIFO && rd_idx == 6'h00 && ctrl[`UTX_CTRL_GFC_EN])
    |=> tx_line_data[7:4] == $past(gfc_bits)) else $error("flow-control bits not replaced");
  a_byte_tick: assert property (@(posedge clock) disable iff (rst)
    tick |=> !tick && tx_byte_clock) else $error("byte clock edge misplaced");
  a_irq_level: assert property (@(posedge clock) disable iff (rst)
    (|(status & mask)) |=> irq) else $error("unmasked status without interrupt");

endmodule : utx_tx_cell_port

/* File: testbench/utx_sar_model.sv */
/*
  Writer-side model: turns one request from the bench into one byte write on the next cycle.
  Assumes requests are raised by non-blocking assignment at the rising clock edge.
*/
`timescale 1ns/1ps
module utx_sar_model
  import utx_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    req,
  input  wire utx_wr_s req_w,
  output utx_wr_s      wr,
  output logic         wr_en_n
);
  initial
  begin
    wr      = '0;
    wr_en_n = 1'b1;
  end

  always @(posedge clock)
  begin
    // Idle data lines flip so a design that samples them without enable cannot match by luck.
    wr_en_n <= rst || !req;
    wr      <= (rst || !req) ? ~wr : req_w;
  end
endmodule : utx_sar_model

/* File: testbench/utx_tx_cell_port_bench.sv */
/*
  Self-checking bench of the transmit cell port with a queue model of the FIFO and the line stream.
  Assumes the writer model utx_sar_model and one 100 MHz clock.
*/
`timescale 1ns/1ps
`include "utx_regs.svh"
module utx_tx_cell_port_bench;
  import utx_pkg::*;
  localparam int CELLS = 2;
  localparam int DEPTH = CELLS * `UTX_CELL_BYTES;
  localparam logic [5:0] CFG [4] = '{6'h00, 6'h04, 6'h14, 6'h02};
  localparam logic [3:0] AV = 4'b1101;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, tx_cell_avail, flow_ctrl_marker, tx_byte_clock, tx_line_idle;
  logic [7:0]  tx_line_data;
  logic        force_idle_cells = 1'b0;
  logic        serial_flow_ctrl_in = 1'b0;
  logic        req = 1'b0;
  utx_wr_s     req_w = '0;
  utx_wr_s     wr;
  logic        wr_en_n;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          cnt = 0;
  int          idx = 0;
  logic [7:0]  q [$];
  logic [2:0]  st_m = '0;
  logic [3:0]  gfc = '0;
  logic        seen = 0, even = 0, gfc_en = 0, fi_hold = 0, synced = 0, cell_fifo = 0, bc_q = 0, sfc_q = 0;
  logic [31:0] r;
  logic        e;

  always #5 clock = ~clock;

  utx_sar_model utx_sar_model_i (.clock(clock), .rst(rst), .req(req), .req_w(req_w), .wr(wr), .wr_en_n(wr_en_n));

  utx_tx_cell_port #(.FIFO_CELLS(CELLS), .BYTE_DIV(2)) utx_tx_cell_port_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .tx_cell_data(wr.data),
    .tx_cell_parity(wr.parity), .tx_start_of_cell(wr.soc), .tx_write_enable_n(wr_en_n),
    .tx_cell_avail(tx_cell_avail), .force_idle_cells(force_idle_cells), .serial_flow_ctrl_in(serial_flow_ctrl_in),
    .flow_ctrl_marker(flow_ctrl_marker), .tx_byte_clock(tx_byte_clock), .tx_line_data(tx_line_data),
    .tx_line_idle(tx_line_idle));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // Only the bench timeout ends this wait, so a slave that never answers fails the run.
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle cycle keeps a following call from driving psel twice in one time step.
    @(posedge clock);
  endtask : apb

  // Sends n bytes; soc_at marks a start byte, bad_at a byte with wrong parity, gap halves the rate.
  task automatic send(input int n, input logic soc0, input int bad_at, input int soc_at, input logic gap);
    logic [7:0] d;
    logic       s;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      s = (soc0 && i == 0) || i == soc_at;
      req   <= 1'b1;
      req_w <= '{data: d, parity: (~^d) ^ even ^ (i == bad_at), soc: s};
      if (s || seen)
      begin
        // A start away from a 53-byte boundary of the running count is early, also after implicit cells.
        if (s && seen && (cnt % 53) != 0)
          st_m[1] = 1'b1;
        cnt = s ? 1 : cnt + 1;
        if (i == bad_at)
          st_m[0] = 1'b1;
        if (q.size() >= DEPTH)
          st_m[2] = 1'b1;
        else
          q.push_back(d);
        seen = 1'b1;
      end
      @(posedge clock);
      if (gap)
      begin
        req <= 1'b0;
        @(posedge clock);
      end
    end
    req <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : send

  always @(posedge clock)
    serial_flow_ctrl_in <= 1'($urandom);

  always @(negedge clock)
  begin
    if (!rst && tx_byte_clock && !bc_q)
    begin
      idx = synced ? (idx + 1) % 53 : 48;
      if (synced)
        chk(flow_ctrl_marker, idx == 48);
      synced = synced | flow_ctrl_marker;
      if (synced)
      begin
        if (idx == 0)
          cell_fifo = !tx_line_idle;
        chk(tx_line_idle, !cell_fifo);
        if (fi_hold)
          chk(tx_line_idle, 1'b1);
        if (tx_line_idle)
          chk(tx_line_data, idx < 3 ? 8'h00 : idx == 3 ? 8'h01 : idx == 4 ? 8'h52 : 8'h6a);
        else
          chk(tx_line_data, (idx == 0 && gfc_en) ? {gfc, q[0][3:0]} : q[0]);
        if (!tx_line_idle)
          void'(q.pop_front());
        if (idx >= 49)
          gfc = {gfc[2:0], sfc_q};
      end
    end
    bc_q  = tx_byte_clock;
    sfc_q = serial_flow_ctrl_in;
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      fails++;
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'h7383));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int a = 0; a < 12; a += 4)
    begin
      apb(1'b0, 12'(a), '0, r, e);
      chk(r, 32'h0);
    end
    apb(1'b0, 12'h010, '0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    chk(tx_cell_avail, 1'b0);
    $display("test reset done");

    force_idle_cells <= 1'b1;
    repeat (300) @(posedge clock);
    fi_hold = 1'b1;
    apb(1'b1, `UTX_ADDR_MASK, 32'h7, r, e);
    send(3, 1'b0, -1, -1, 1'b0);
    send(10, 1'b1, 2, -1, 1'b1);
    send(53, 1'b1, -1, -1, 1'b0);
    send(44, 1'b0, -1, -1, 1'b0);
    apb(1'b0, `UTX_ADDR_LEVEL, '0, r, e);
    chk(r, 32'h10000 | q.size());
    apb(1'b0, `UTX_ADDR_STATUS, '0, r, e);
    chk(r, {29'h0, st_m});
    chk(irq, 1'b1);
    apb(1'b1, `UTX_ADDR_MASK, 32'h0, r, e);
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    apb(1'b1, `UTX_ADDR_MASK, 32'h7, r, e);
    apb(1'b1, `UTX_ADDR_STATUS, 32'h7, r, e);
    st_m = '0;
    repeat (3) @(posedge clock);
    chk(irq, 1'b0);
    foreach (CFG[i])
    begin
      apb(1'b1, `UTX_ADDR_CTRL, {26'h0, CFG[i]}, r, e);
      repeat (3) @(posedge clock);
      chk(tx_cell_avail, AV[i]);
    end
    $display("test fill done");

    even   = 1'b1;
    gfc_en = 1'b1;
    apb(1'b1, `UTX_ADDR_CTRL, 32'h21, r, e);
    fi_hold = 1'b0;
    force_idle_cells <= 1'b0;
    repeat (600) @(posedge clock);
    send(53, 1'b1, -1, -1, 1'b1);
    send(53, 1'b0, -1, -1, 1'b1);
    repeat (600) @(posedge clock);
    apb(1'b0, `UTX_ADDR_STATUS, '0, r, e);
    chk(r, {29'h0, st_m});
    chk(q.size(), 0);
    apb(1'b0, `UTX_ADDR_LEVEL, '0, r, e);
    chk(r, 32'h0);
    $display("test drain done");
    end_sim();
  end
endmodule : utx_tx_cell_port_bench
